//--- sbg_pkg.sv
package sbg_pkg;
   localparam int unsigned PORT_W = 7;
   // reset values: all inputs, pull enabled, pull toward io_supply
   localparam logic [6:0] DIR_RST    = 7'h00;
   localparam logic [6:0] LATCH_RST  = 7'h7f;
   localparam logic [6:0] DRIVE_RST  = 7'h00;
   localparam logic [6:0] PULLUP_RST = 7'h7f;
   localparam logic [6:0] IE_RST     = 7'h00;
   localparam logic [6:0] EDGE_RST   = 7'h00;
   // bits with an alternate_function (port bits 4, 6 and 7 -> indices 4,5,6 of a 7-bit port)
   localparam logic [6:0] ALT_CAPABLE = 7'h70;

   // per-pin pad control handed to the pad ring
   typedef struct packed {
      logic [6:0] out_val;    // level driven when enabled
      logic [6:0] out_en_n;   // low while the pin is driven
      logic [6:0] pull_en;    // pull resistor on
      logic [6:0] pull_up;    // 1: toward io_supply, 0: toward io_ground
      logic [6:0] drive_hi;   // 1: higher drive setting
   } sbg_pad_s;

   // configuration bits from software
   typedef struct packed {
      logic [6:0] direction_select;
      logic [6:0] drive_strength_select;
      logic [6:0] pull_polarity_select;
      logic [6:0] irq_enable;
      logic [6:0] edge_rising;          // 1: rising edge, 0: falling edge
      logic [6:0] alt_select;           // hand pin to the timer channel
   } sbg_cfg_s;
endpackage

//--- sbg_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for one pin
module sbg_sync
   import sbg_pkg::*;
(
   input  wire logic mclk_i,
   input  wire logic rst_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         meta_q <= 1'b1;
         q_o    <= 1'b1;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule // sbg_sync

//--- sbg_gpio.sv
`timescale 1ns/1ps
module sbg_gpio
   import sbg_pkg::*;
(
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   input  wire logic [6:0] pin_i,            // pad input levels
   output sbg_pad_s        pad_o,            // pad controls
   input  wire sbg_cfg_s   cfg_i,            // software configuration
   input  wire logic       latch_wr_i,       // output_latch write strobe
   input  wire logic [6:0] latch_wdata_i,
   output logic [6:0]      output_latch_o,
   output logic [6:0]      pin_level_readback_o,
   input  wire logic [6:0] flag_clr_i,       // one-cycle clear per flag
   output logic [6:0]      event_flag_o,
   output logic [6:0]      irq_req_o,        // per-pin requests
   output logic            irq_o,            // any enabled request
   input  wire logic       stop_mode_i,
   output logic            wake_o,
   input  wire logic [6:0] timer_out_i,      // timer channel drive value
   input  wire logic [6:0] timer_oe_i,       // timer channel wants to drive
   output logic [6:0]      timer_sense_o     // synchronised level to timer
);
   logic [6:0] sync_w;
   logic [6:0] prev_q;
   logic [6:0] latch_q;
   logic [6:0] flag_q;
   logic [6:0] edge_w;
   logic [6:0] alt_w;
   logic [6:0] drv_w;
   logic [6:0] val_w;

   // one synchroniser per pin, asynchronous edges land safely
   genvar gi;
   generate
      for (gi = 0; gi < PORT_W; gi++) begin : g_sync
         sbg_sync u_sync (
            .mclk_i (mclk_i),
            .rst_i  (rst_i),
            .d_i    (pin_i[gi]),
            .q_o    (sync_w[gi])
         );
      end
   endgenerate

   // output latch, reset high so pulls are on
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         latch_q <= LATCH_RST;
      end else if (latch_wr_i) begin
         latch_q <= latch_wdata_i;
      end
   end

   // pin state one cycle behind for edge detection
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         prev_q <= 7'h7f;
      end else begin
         prev_q <= sync_w;
      end
   end

   // rising or falling edge per configuration
   assign edge_w = cfg_i.edge_rising & sync_w & ~prev_q
                 | ~cfg_i.edge_rising & ~sync_w & prev_q;

   // sticky flags; set beats a clear in the same cycle
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         flag_q <= 7'h00;
      end else begin
         flag_q <= (flag_q & ~flag_clr_i) | edge_w;
      end
   end

   // alternate function only where the pin supports it
   assign alt_w = cfg_i.alt_select & ALT_CAPABLE;
   // direction: timer owns the pin when alternate function picked
   assign drv_w = (alt_w & timer_oe_i) | (~alt_w & cfg_i.direction_select);
   assign val_w = (alt_w & timer_out_i) | (~alt_w & latch_q);

   // pad controls registered so outputs come from flip-flops
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pad_o.out_val  <= 7'h00;
         pad_o.out_en_n <= 7'h7f;
         pad_o.pull_en  <= LATCH_RST;
         pad_o.pull_up  <= PULLUP_RST;
         pad_o.drive_hi <= DRIVE_RST;
      end else begin
         pad_o.out_val  <= val_w;
         pad_o.out_en_n <= ~drv_w;
         pad_o.pull_en  <= ~drv_w & latch_q;
         pad_o.pull_up  <= cfg_i.pull_polarity_select;
         pad_o.drive_hi <= cfg_i.drive_strength_select & drv_w;
      end
   end

   assign output_latch_o       = latch_q;
   assign pin_level_readback_o = sync_w;
   assign timer_sense_o        = sync_w;
   assign event_flag_o         = flag_q;
   assign irq_req_o            = flag_q & cfg_i.irq_enable;
   assign irq_o                = |irq_req_o;
   // wake is a level; the clock may be stopped, so no registering here
   assign wake_o               = stop_mode_i & irq_o;

   property p_flag_sets;
      @(posedge mclk_i) disable iff (rst_i)
      (edge_w[0]) |=> flag_q[0];
   endproperty
   a_flag_sets: assert property (p_flag_sets) else $error("edge did not set flag");

   property p_flag_sticky;
      @(posedge mclk_i) disable iff (rst_i)
      (flag_q[1] && !flag_clr_i[1]) |=> flag_q[1];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear");

   property p_irq_gate;
      @(posedge mclk_i) disable iff (rst_i)
      irq_o |-> |(flag_q & cfg_i.irq_enable);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("request without enabled flag");

   property p_wake;
      @(posedge mclk_i) disable iff (rst_i)
      (stop_mode_i && |(flag_q & cfg_i.irq_enable)) |-> wake_o;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake in stop mode");

   property p_drive_follows;
      @(posedge mclk_i) disable iff (rst_i)
      (cfg_i.direction_select[2] && !alt_w[2]) |=> (!pad_o.out_en_n[2] && pad_o.out_val[2] == $past(latch_q[2]));
   endproperty
   a_drive_follows: assert property (p_drive_follows) else $error("output pin not driven from latch");

   property p_pull_input;
      @(posedge mclk_i) disable iff (rst_i)
      (!cfg_i.direction_select[3] && !alt_w[3]) |=> (pad_o.pull_en[3] == $past(latch_q[3]) && pad_o.out_en_n[3]);
   endproperty
   a_pull_input: assert property (p_pull_input) else $error("input pull not from latch");

   property p_readback_delay;
      @(posedge mclk_i) disable iff (rst_i)
      ##2 (pin_level_readback_o == $past(pin_i, 2));
   endproperty
   a_readback_delay: assert property (p_readback_delay) else $error("readback not two stages behind");

   property p_polarity;
      @(posedge mclk_i) disable iff (rst_i)
      1'b1 |=> pad_o.pull_up == $past(cfg_i.pull_polarity_select);
   endproperty
   a_polarity: assert property (p_polarity) else $error("pull polarity mismatch");

   property p_alt_masked;
      @(posedge mclk_i) disable iff (rst_i)
      (cfg_i.alt_select[0] && cfg_i.direction_select[0] == 1'b0) |=> pad_o.out_en_n[0];
   endproperty
   a_alt_masked: assert property (p_alt_masked) else $error("alternate function on unsupported bit");

   // checks against inputs and across pad fields, except a_flag_clears, which conditions on the internal edge_w term
   property p_latch_write;
      @(posedge mclk_i) disable iff (rst_i)
      latch_wr_i |=> output_latch_o == $past(latch_wdata_i);
   endproperty
   a_latch_write: assert property (p_latch_write) else $error("latch write lost");

   property p_latch_hold;
      @(posedge mclk_i) disable iff (rst_i)
      !latch_wr_i |=> $stable(output_latch_o);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch changed without write");

   property p_flag_clears;
      @(posedge mclk_i) disable iff (rst_i)
      (flag_clr_i[0] && !edge_w[0]) |=> !event_flag_o[0];
   endproperty
   a_flag_clears: assert property (p_flag_clears) else $error("flag not cleared");

   property p_rising_sets;
      @(posedge mclk_i) disable iff (rst_i)
      (cfg_i.edge_rising[1] && pin_level_readback_o[1] && !$past(pin_level_readback_o[1])) |=> event_flag_o[1];
   endproperty
   a_rising_sets: assert property (p_rising_sets) else $error("rising edge missed");

   property p_drive_only_out;
      @(posedge mclk_i) disable iff (rst_i)
      (pad_o.drive_hi & pad_o.out_en_n) == 7'h00;
   endproperty
   a_drive_only_out: assert property (p_drive_only_out) else $error("drive strength on undriven pin");

   property p_pull_off_driven;
      @(posedge mclk_i) disable iff (rst_i)
      (pad_o.pull_en & ~pad_o.out_en_n) == 7'h00;
   endproperty
   a_pull_off_driven: assert property (p_pull_off_driven) else $error("pull on while driving");

   property p_plain_bits;
      @(posedge mclk_i) disable iff (rst_i)
      1'b1 |=> pad_o.out_en_n[3:0] == ~$past(cfg_i.direction_select[3:0]);
   endproperty
   a_plain_bits: assert property (p_plain_bits) else $error("plain bit direction wrong");

   property p_timer_drives;
      @(posedge mclk_i) disable iff (rst_i)
      (cfg_i.alt_select[4] && timer_oe_i[4])
         |=> (!pad_o.out_en_n[4] && pad_o.out_val[4] == $past(timer_out_i[4]));
   endproperty
   a_timer_drives: assert property (p_timer_drives) else $error("timer does not drive its pin");

   property p_reset_state;
      @(posedge mclk_i)
      rst_i |=> (output_latch_o == LATCH_RST && pad_o.out_en_n == 7'h7f && pad_o.pull_up == PULLUP_RST
                 && event_flag_o == 7'h00);
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
endmodule // sbg_gpio

//--- sbg_pins.sv
`timescale 1ns/1ps
// far-side pin circuitry: pulls plus one external source per pin
module sbg_pins
   import sbg_pkg::*;
(
   input  wire logic       mclk_i,
   input  wire sbg_pad_s   pad_i,
   input  wire logic [6:0] ext_en_i,
   input  wire logic [6:0] ext_val_i,
   output logic [6:0]      pin_o
);
   logic [6:0] float_q = 7'h00;
   // an undriven pin wanders so a stale level never reads as a match
   always_ff @(posedge mclk_i) begin
      float_q <= ~float_q;
   end
   // device drive wins, then the external source, then the pull
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         if (!pad_i.out_en_n[i]) pin_o[i] = pad_i.out_val[i];
         else if (ext_en_i[i]) pin_o[i] = ext_val_i[i];
         else if (pad_i.pull_en[i]) pin_o[i] = pad_i.pull_up[i];
         else pin_o[i] = float_q[i];
      end
   end
endmodule // sbg_pins

//--- sbg_gpio_bench.sv
`timescale 1ns/1ps
module sbg_gpio_bench;
   import sbg_pkg::*;
   logic       mclk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       wr = 1'b0;
   logic       stop = 1'b0;
   logic [6:0] wdata = 7'h00;
   logic [6:0] clr = 7'h00;
   logic [6:0] t_out = 7'h00;
   logic [6:0] t_oe = 7'h00;
   logic [6:0] ext_en = 7'h00;
   logic [6:0] ext_val = 7'h00;
   logic [6:0] pins, latch, rdbk, flag, req, sense;
   logic       irq, wake;
   // pull polarity starts toward io_supply, as after power-up
   sbg_cfg_s   cfg = {7'h00, 7'h00, PULLUP_RST, 7'h00, 7'h00, 7'h00};
   sbg_pad_s   pad;
   int         mismatches = 0;
   int         n_compared = 0;
   int         cycles = 0;
   always #5 mclk_i = ~mclk_i;
   sbg_gpio sbg_gpio_inst (.mclk_i(mclk_i), .rst_i(rst_i), .pin_i(pins), .pad_o(pad), .cfg_i(cfg),
      .latch_wr_i(wr), .latch_wdata_i(wdata), .output_latch_o(latch), .pin_level_readback_o(rdbk),
      .flag_clr_i(clr), .event_flag_o(flag), .irq_req_o(req), .irq_o(irq), .stop_mode_i(stop),
      .wake_o(wake), .timer_out_i(t_out), .timer_oe_i(t_oe), .timer_sense_o(sense));
   sbg_pins sbg_pins_inst (.mclk_i(mclk_i), .pad_i(pad), .ext_en_i(ext_en), .ext_val_i(ext_val),
      .pin_o(pins));
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [6:0] got, input logic [6:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // let edges land, then sample off the edge
   task automatic settle(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic wr_latch(input logic [6:0] v);
      @(posedge mclk_i);
      wr    <= 1'b1;
      wdata <= v;
      @(posedge mclk_i);
      wr <= 1'b0;
   endtask
   // hang guard, well above the 70 or so cycles the tests use
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      settle(8);
      @(posedge mclk_i) rst_i <= 1'b0;
      settle(1);
      chk(latch, 7'h7f);
      chk(pad.out_en_n, 7'h7f);
      chk(pad.pull_en & pad.pull_up, 7'h7f);
      settle(3);
      chk(rdbk, 7'h7f);
      $display("reset test done");
      // outputs: direction, level and drive strength per pin
      @(posedge mclk_i) begin cfg.direction_select <= 7'h7f; cfg.drive_strength_select <= 7'h0f; end
      wr_latch(7'h55);
      settle(6);
      chk(pad.out_en_n, 7'h00);
      chk(pad.out_val, 7'h55);
      chk(pad.drive_hi, 7'h0f);
      chk(rdbk, 7'h55);
      $display("output test done");
      // inputs: latch bit turns the pull on or off, polarity per pin
      @(posedge mclk_i) begin cfg.direction_select <= 7'h00; cfg.pull_polarity_select <= 7'h03; end
      wr_latch(7'h0f);
      settle(4);
      chk(latch, 7'h0f);
      chk(pad.pull_en, 7'h0f);
      chk(pad.pull_up & 7'h0f, 7'h03);
      wr_latch(7'h7f);
      @(posedge mclk_i) cfg.pull_polarity_select <= 7'h7f;
      settle(5);
      @(posedge mclk_i) clr <= 7'h7f;
      @(posedge mclk_i) clr <= 7'h00;
      $display("pull test done");
      // bit0 falling enabled, bit1 rising masked; later bit1 rise sets its flag but adds no request
      @(posedge mclk_i) begin cfg.edge_rising <= 7'h02; cfg.irq_enable <= 7'h01; stop <= 1'b1; end
      @(posedge mclk_i) ext_en <= 7'h03;
      settle(5);
      chk(flag, 7'h01);
      chk({req[6:1], irq & wake}, 7'h01);
      @(posedge mclk_i) ext_en <= 7'h01;
      settle(5);
      @(posedge mclk_i) ext_en <= 7'h00;
      settle(5);
      chk(flag, 7'h03);
      chk(req, 7'h01);
      @(posedge mclk_i) clr <= 7'h03;
      @(posedge mclk_i) clr <= 7'h00;
      settle(2);
      chk({flag[6:1], irq | wake}, 7'h00);
      $display("edge test done");
      // timer takes bit4 and drives it low with its pull switched off; alt select on bit0 is ignored
      @(posedge mclk_i) begin
         cfg.alt_select <= 7'h11;
         t_oe           <= 7'h11;
         t_out          <= 7'h01;
      end
      settle(6);
      chk(pad.out_en_n, 7'h6f);
      chk(pad.out_val & 7'h11, 7'h01);
      chk(sense, 7'h6f);
      $display("alternate test done");
      conclude();
   end
endmodule // sbg_gpio_bench
